/* mgs_params.svh */
// Constants shared by both ends of the serial management link
`ifndef MGS_PARAMS_SVH
`define MGS_PARAMS_SVH

`define MGS_CLK_MHZ 100
`define MGS_MDC_MAX_MHZ 25
`define MGS_MDC_HALF ((`MGS_CLK_MHZ + 2 * `MGS_MDC_MAX_MHZ - 1) / (2 * `MGS_MDC_MAX_MHZ))

`define MGS_DATA_W 16
`define MGS_ADDR_W 5
`define MGS_NREGS 32
`define MGS_NPORTS 2
`define MGS_WORD_W 22

`define MGS_PRE_ONES 6'd32
`define MGS_ST 2'b01
`define MGS_OP_RD 2'b10
`define MGS_OP_WR 2'b01
`define MGS_TA_WR 2'b10
`define MGS_STATUS_REG 5'h01
`define MGS_PRESUP_BIT 6

`define MGS_ADDR_LAST 5'd9
`define MGS_DATA_LAST 5'd15
`define MGS_FRAME_BITS 64
`define MGS_TA_FIRST 7'd46
`define MGS_RD_FIRST 7'd48
`define MGS_CLOSE_BIT 7'd64
`define MGS_DONE_BIT 7'd66

`endif

/* mgs_pkg.sv */
// Types for the serial management link ends
`include "mgs_params.svh"

package mgs_pkg;

	typedef enum logic [2:0] {
		MGS_HUNT,
		MGS_START,
		MGS_OPCODE,
		MGS_ADDR,
		MGS_TA1,
		MGS_TA2,
		MGS_DATA,
		MGS_CLOSE
	} mgs_dev_state_type;

	typedef logic [`MGS_WORD_W-1:0] mgs_word_type;

	typedef struct packed {
		mgs_dev_state_type st;
		logic [5:0] ones;
		logic [4:0] cnt;
		logic rd;
		logic hit;
		logic port;
		logic [2*`MGS_ADDR_W-1:0] addr;
		logic [`MGS_DATA_W-1:0] sh;
		logic mdo;
		logic mdoe;
		logic [`MGS_NPORTS-1:0][`MGS_NREGS-1:0][`MGS_DATA_W-1:0] mem;
		mgs_word_type wr_word;
		logic wr_tog;
		logic us1;
		logic us2;
		logic us3;
		logic useen;
	} mgs_dev_link_type;

	typedef struct packed {
		logic ws1;
		logic ws2;
		logic ws3;
		logic wseen;
		logic wr_valid;
		mgs_word_type wr_word;
		logic upd_tog;
		mgs_word_type upd_word;
		logic as1;
		logic as2;
		logic as3;
	} mgs_dev_user_type;

	typedef enum logic {
		MGS_C_IDLE,
		MGS_C_RUN
	} mgs_ctl_state_type;

	typedef struct packed {
		mgs_ctl_state_type st;
		logic [7:0] div;
		logic mdc;
		logic [6:0] bitn;
		logic [`MGS_FRAME_BITS-1:0] frame;
		logic rd;
		logic [`MGS_DATA_W-1:0] rdata;
		logic rsp;
		logic mo;
		logic moe;
		logic s1;
		logic s2;
		logic s3;
	} mgs_ctl_type;

endpackage

/* mgs_if.sv */
// Link between management controller and device: clock plus shared data line
`timescale 1ns/10ps

interface mgs_if;
	logic mdc;
	logic dev_o;
	logic dev_oe;
	logic ctl_o;
	logic ctl_oe;
	logic mdio;

	// Released line reads high through the pull-up
	assign mdio = dev_oe ? dev_o : (ctl_oe ? ctl_o : 1'b1);

	modport dev (
		input mdc,
		input mdio,
		output dev_o,
		output dev_oe
	);

	modport ctl (
		output mdc,
		output ctl_o,
		output ctl_oe,
		input mdio
	);
endinterface

/* mgs_dev.sv */
// Management slave: frame decoder on the link clock and register shadow
//
// What this block does
// - Controller clocks up to 25MHz; sample rising.
// - Controller holds each bit one clock period.
// - Need 32 ones unless preamble suppression set.
// - Start pattern 01 opens instruction fields.
// - Opcode 10 reads, 01 writes.
// - Five-bit PHY address, MSB first, any value.
// - Five-bit register address, MSB first.
// - Controller drives 10 in write turnaround.
// - Read turnaround: first undriven, second zero.
// - Sixteen data bits, MSB first, both directions.
// - Read bit changes at rising edge, holds.
// - Controller leaves an idle bit between frames.
// - Device drives last 17 read bits, releases.
// - Sixty-fifth pulse commits a pending write.
`timescale 1ns/10ps
`include "mgs_params.svh"

module mgs_dev #(
	parameter logic [`MGS_ADDR_W-1:0] PHY_BASE = 5'h00
) (
	input wire clk,
	input wire sys_rst,
	mgs_if.dev link,
	output logic wr_valid,
	output logic wr_port,
	output logic [`MGS_ADDR_W-1:0] wr_reg,
	output logic [`MGS_DATA_W-1:0] wr_data,
	input wire upd_valid,
	output logic upd_ready,
	input wire upd_port,
	input wire [`MGS_ADDR_W-1:0] upd_reg,
	input wire [`MGS_DATA_W-1:0] upd_data
);
	import mgs_pkg::*;

	mgs_dev_link_type ln_q;
	mgs_dev_link_type ln_d;
	mgs_dev_user_type us_q;
	mgs_dev_user_type us_d;

	// Link side: every step happens on a rising edge of the management clock
	always_comb begin
		logic [2*`MGS_ADDR_W-1:0] addr_n;
		logic presup;
		logic commit;
		logic [`MGS_DATA_W-1:0] word;
		addr_n = {ln_q.addr[2*`MGS_ADDR_W-2:0], link.mdio};
		presup = ln_q.mem[0][`MGS_STATUS_REG][`MGS_PRESUP_BIT]
			| ln_q.mem[1][`MGS_STATUS_REG][`MGS_PRESUP_BIT];
		commit = 1'b0;
		word = ln_q.mem[ln_q.port][ln_q.addr[`MGS_ADDR_W-1:0]];
		ln_d = ln_q;
		unique case (ln_q.st)
			MGS_HUNT: begin
				ln_d.mdoe = 1'b0;
				if (link.mdio) begin
					if (ln_q.ones != `MGS_PRE_ONES) begin
						ln_d.ones = ln_q.ones + 6'h01;
					end
				end else if (ln_q.ones == `MGS_PRE_ONES || presup) begin
					ln_d.st = MGS_START;
				end else begin
					ln_d.ones = 6'h00;
				end
			end
			MGS_START: begin
				ln_d.cnt = 5'h00;
				if (link.mdio) begin
					ln_d.st = MGS_OPCODE;
				end else begin
					ln_d.st = MGS_HUNT;
					ln_d.ones = 6'h00;
				end
			end
			MGS_OPCODE: begin
				ln_d.cnt = ln_q.cnt + 5'h01;
				if (ln_q.cnt == 5'h00) begin
					ln_d.rd = link.mdio;
				end else if ({ln_q.rd, link.mdio} == `MGS_OP_RD
					|| {ln_q.rd, link.mdio} == `MGS_OP_WR) begin
					ln_d.st = MGS_ADDR;
					ln_d.cnt = 5'h00;
				end else begin
					ln_d.st = MGS_HUNT;
					ln_d.ones = 6'h00;
				end
			end
			MGS_ADDR: begin
				ln_d.addr = addr_n;
				ln_d.cnt = ln_q.cnt + 5'h01;
				if (ln_q.cnt == `MGS_ADDR_LAST) begin
					ln_d.st = MGS_TA1;
					// Any of the 32 addresses may arrive; only our two ports answer
					ln_d.hit = (addr_n[2*`MGS_ADDR_W-1:`MGS_ADDR_W] == PHY_BASE)
						|| (addr_n[2*`MGS_ADDR_W-1:`MGS_ADDR_W] == PHY_BASE + 5'h01);
					ln_d.port = (addr_n[2*`MGS_ADDR_W-1:`MGS_ADDR_W] != PHY_BASE);
				end
			end
			MGS_TA1: begin
				ln_d.st = MGS_TA2;
				if (ln_q.rd && ln_q.hit) begin
					ln_d.mdoe = 1'b1;
					ln_d.mdo = 1'b0;
				end
			end
			MGS_TA2: begin
				// Write turnaround content is not checked; the data field decides
				ln_d.st = MGS_DATA;
				ln_d.cnt = 5'h00;
				if (ln_q.rd && ln_q.hit) begin
					ln_d.mdo = word[`MGS_DATA_W-1];
					ln_d.sh = {word[`MGS_DATA_W-2:0], 1'b0};
				end
			end
			MGS_DATA: begin
				ln_d.cnt = ln_q.cnt + 5'h01;
				if (ln_q.rd) begin
					ln_d.mdo = ln_q.sh[`MGS_DATA_W-1];
					ln_d.sh = {ln_q.sh[`MGS_DATA_W-2:0], 1'b0};
				end else begin
					ln_d.sh = {ln_q.sh[`MGS_DATA_W-2:0], link.mdio};
				end
				if (ln_q.cnt == `MGS_DATA_LAST) begin
					ln_d.st = MGS_CLOSE;
					ln_d.mdoe = 1'b0;
				end
			end
			MGS_CLOSE: begin
				ln_d.st = MGS_HUNT;
				ln_d.ones = 6'h00;
				if (!ln_q.rd && ln_q.hit) begin
					commit = 1'b1;
					ln_d.mem[ln_q.port][ln_q.addr[`MGS_ADDR_W-1:0]] = ln_q.sh;
					ln_d.wr_word = {ln_q.port, ln_q.addr[`MGS_ADDR_W-1:0], ln_q.sh};
					ln_d.wr_tog = ~ln_q.wr_tog;
				end
			end
		endcase
		// Update word from the user side; a frame commit in the same edge goes first
		ln_d.us1 = us_q.upd_tog;
		ln_d.us2 = ln_q.us1;
		ln_d.us3 = ln_q.us2;
		if (ln_q.us2 == ln_q.us3 && ln_q.us3 != ln_q.useen && !commit) begin
			ln_d.mem[us_q.upd_word[`MGS_WORD_W-1]]
				[us_q.upd_word[`MGS_WORD_W-2:`MGS_DATA_W]] = us_q.upd_word[`MGS_DATA_W-1:0];
			ln_d.useen = ln_q.us3;
		end
	end

	// Sampling and driving both on the rising management clock edge
	always_ff @(posedge link.mdc or posedge sys_rst) begin
		if (sys_rst) begin
			ln_q <= '0;
		end else begin
			ln_q <= ln_d;
		end
	end

	// User side: write reports out, shadow updates in, both by toggle handshake
	always_comb begin
		us_d = us_q;
		us_d.wr_valid = 1'b0;
		us_d.ws1 = ln_q.wr_tog;
		us_d.ws2 = us_q.ws1;
		us_d.ws3 = us_q.ws2;
		// Word is stable here: the link side holds it until the next commit
		if (us_q.ws2 == us_q.ws3 && us_q.ws3 != us_q.wseen) begin
			us_d.wseen = us_q.ws3;
			us_d.wr_valid = 1'b1;
			us_d.wr_word = ln_q.wr_word;
		end
		us_d.as1 = ln_q.useen;
		us_d.as2 = us_q.as1;
		us_d.as3 = us_q.as2;
		if (upd_valid && upd_ready) begin
			us_d.upd_tog = ~us_q.upd_tog;
			us_d.upd_word = {upd_port, upd_reg, upd_data};
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			us_q <= '0;
		end else begin
			us_q <= us_d;
		end
	end

	// An update waits for link clock edges; with the link clock stopped it stalls
	assign upd_ready = (us_q.as2 == us_q.as3) && (us_q.as3 == us_q.upd_tog);
	assign wr_valid = us_q.wr_valid;
	assign wr_port = us_q.wr_word[`MGS_WORD_W-1];
	assign wr_reg = us_q.wr_word[`MGS_WORD_W-2:`MGS_DATA_W];
	assign wr_data = us_q.wr_word[`MGS_DATA_W-1:0];
	assign link.dev_o = ln_q.mdo;
	assign link.dev_oe = ln_q.mdoe;
endmodule

/* mgs_ctl.sv */
// Management controller: makes the link clock and sends one frame per command
`timescale 1ns/10ps
`include "mgs_params.svh"

module mgs_ctl #(
	parameter int unsigned MDC_HALF = `MGS_MDC_HALF
) (
	input wire clk,
	input wire sys_rst,
	mgs_if.ctl link,
	input wire cmd_valid,
	output logic cmd_ready,
	input wire cmd_write,
	input wire [`MGS_ADDR_W-1:0] cmd_phy,
	input wire [`MGS_ADDR_W-1:0] cmd_reg,
	input wire [`MGS_DATA_W-1:0] cmd_wdata,
	output logic rsp_valid,
	output logic [`MGS_DATA_W-1:0] rsp_rdata
);
	import mgs_pkg::*;

	mgs_ctl_type c_q;
	mgs_ctl_type c_d;

	always_comb begin
		logic [6:0] nb;
		nb = c_q.bitn + 7'd1;
		c_d = c_q;
		c_d.rsp = 1'b0;
		c_d.s1 = link.mdio;
		c_d.s2 = c_q.s1;
		c_d.s3 = c_q.s2;
		unique case (c_q.st)
			MGS_C_IDLE: begin
				c_d.mdc = 1'b0;
				c_d.moe = 1'b0;
				if (cmd_valid) begin
					c_d.st = MGS_C_RUN;
					c_d.rd = !cmd_write;
					c_d.bitn = 7'd0;
					c_d.div = 8'h00;
					c_d.frame = {{32{1'b1}}, `MGS_ST,
						cmd_write ? `MGS_OP_WR : `MGS_OP_RD,
						cmd_phy, cmd_reg,
						cmd_write ? `MGS_TA_WR : 2'b11,
						cmd_write ? cmd_wdata : 16'hFFFF};
					c_d.mo = 1'b1;
					c_d.moe = 1'b1;
				end
			end
			MGS_C_RUN: begin
				if (c_q.div == 8'(MDC_HALF - 1)) begin
					c_d.div = 8'h00;
					c_d.mdc = ~c_q.mdc;
					if (!c_q.mdc) begin
						// Rising edge: take the bit the device set one period ago
						if (c_q.rd && c_q.bitn >= `MGS_RD_FIRST && c_q.bitn < `MGS_CLOSE_BIT) begin
							c_d.rdata = {c_q.rdata[`MGS_DATA_W-2:0], c_q.s3};
						end
					end else begin
						// Falling edge: next bit, so each stays a full period
						c_d.bitn = nb;
						c_d.frame = {c_q.frame[`MGS_FRAME_BITS-2:0], 1'b1};
						c_d.mo = c_q.frame[`MGS_FRAME_BITS-2];
						c_d.moe = (nb < `MGS_CLOSE_BIT) && !(c_q.rd && nb >= `MGS_TA_FIRST);
						if (nb == `MGS_DONE_BIT) begin
							// Pulse 65 closed the frame, pulse 66 was an idle bit
							c_d.st = MGS_C_IDLE;
							c_d.rsp = 1'b1;
						end
					end
				end else begin
					c_d.div = c_q.div + 8'h01;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			c_q <= '0;
		end else begin
			c_q <= c_d;
		end
	end

	assign cmd_ready = (c_q.st == MGS_C_IDLE);
	assign rsp_valid = c_q.rsp;
	assign rsp_rdata = c_q.rdata;
	assign link.mdc = c_q.mdc;
	assign link.ctl_o = c_q.mo;
	assign link.ctl_oe = c_q.moe;
endmodule

/* mgs_link_assertions.sv */
// Checker for the shared management line between controller and device
`timescale 1ns/10ps

module mgs_link_assertions (
	input logic mdc,
	input logic sys_rst,
	input logic dev_o,
	input logic dev_oe,
	input logic ctl_oe,
	input logic mdio
);
	logic [6:0] bitn_q;

	// Frame bit position; holds while the link clock is stopped between frames
	always_ff @(posedge mdc or posedge sys_rst) begin
		if (sys_rst) begin
			bitn_q <= 7'h00;
		end else if (bitn_q == 7'h41) begin
			bitn_q <= 7'h00;
		end else if (bitn_q != 7'h00 || ctl_oe) begin
			bitn_q <= bitn_q + 7'h01;
		end
	end

	default clocking cb @(posedge mdc); endclocking
	default disable iff (sys_rst);

	a_pre_ones: assert property (ctl_oe && bitn_q < 7'h20 |-> mdio)
		else $error("preamble bit low");
	a_start_pat: assert property (bitn_q == 7'h20 |-> !mdio ##1 mdio)
		else $error("start pattern wrong");
	a_op_code: assert property (bitn_q == 7'h23 |-> mdio != $past(mdio))
		else $error("opcode neither read nor write");
	a_wr_turn: assert property (ctl_oe && bitn_q == 7'h2E |-> mdio ##1 !mdio)
		else $error("write turnaround wrong");
	a_ta_release: assert property (bitn_q == 7'h2E |-> !dev_oe)
		else $error("device drives first turnaround bit");
	a_ta_zero: assert property ($rose(dev_oe) |-> bitn_q == 7'h2F && !dev_o)
		else $error("second turnaround bit not zero");
	a_drive_len: assert property ($rose(dev_oe) |->
		dev_oe[*8] ##1 dev_oe[*8] ##1 dev_oe ##1 !dev_oe)
		else $error("device drive not 17 bits");
	a_no_clash: assert property (!(dev_oe && ctl_oe))
		else $error("both ends drive the line");
	a_idle_bit: assert property (bitn_q >= 7'h40 |-> !ctl_oe && !dev_oe && mdio)
		else $error("line not released at frame end");

	c_read: cover property ($rose(dev_oe));
	c_write: cover property (ctl_oe && bitn_q == 7'h2E);
	c_frame_end: cover property (bitn_q == 7'h41);
endmodule

/* mdio_management_slave_tb.sv */
// Bench: controller and device on one link, a second device driven bit by bit
`timescale 1ns/10ps
`include "mgs_params.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("[ERR] %0t got %h want %h", $time, (a), (b)); end end

module mdio_management_slave_tb;
	logic clk = 0, sys_rst = 1, cmd_valid = 0, cmd_write = 0, upd_valid = 0, upd_port = 0;
	logic [4:0] cmd_phy = 0, cmd_reg = 0, upd_reg = 0, wr_reg;
	logic [15:0] cmd_wdata = 0, upd_data = 0, rsp_rdata, rdata, wr_data;
	logic cmd_ready, rsp_valid, upd_ready, wr_valid, wr_port, wr_valid_b;
	int num_errors = 0, n_checks = 0, cyc = 0, n_wr = 0, n_wr_b = 0, n_mdc = 0;
	mgs_if link_a();
	mgs_if link_b();

	mgs_ctl u_mgs_ctl (.clk, .sys_rst, .link(link_a.ctl), .cmd_valid, .cmd_ready, .cmd_write,
		.cmd_phy, .cmd_reg, .cmd_wdata, .rsp_valid, .rsp_rdata);
	mgs_dev #(.PHY_BASE(5'h1E)) u_mgs_dev (.clk, .sys_rst, .link(link_a.dev), .wr_valid,
		.wr_port, .wr_reg, .wr_data, .upd_valid, .upd_ready, .upd_port, .upd_reg, .upd_data);
	// Second device sees valid frames and frames that break the framing on purpose
	mgs_dev u_mgs_dev_b (.clk, .sys_rst, .link(link_b.dev), .wr_valid(wr_valid_b), .wr_port(),
		.wr_reg(), .wr_data(), .upd_valid(1'b0), .upd_ready(), .upd_port(1'b0),
		.upd_reg(5'h00), .upd_data(16'h0000));
	mgs_link_assertions u_chk (.mdc(link_a.mdc), .sys_rst, .dev_o(link_a.dev_o),
		.dev_oe(link_a.dev_oe), .ctl_oe(link_a.ctl_oe), .mdio(link_a.mdio));

	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			stop_test();
		end
	end
	always @(negedge clk) begin
		n_wr += (wr_valid === 1'b1);
		n_wr_b += (wr_valid_b === 1'b1);
	end
	always @(posedge link_a.mdc) n_mdc++;

	task stop_test;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task run(input logic w, input logic [4:0] p, r, input logic [15:0] d);
		int k;
		@(negedge clk);
		{cmd_valid, cmd_write, cmd_phy, cmd_reg, cmd_wdata} = {1'b1, w, p, r, d};
		n_mdc = 0;
		k = 0;
		while (cmd_ready !== 1'b1 && k < 400) begin
			@(negedge clk);
			k++;
		end
		@(negedge clk);
		cmd_valid = 0;
		`CHK(cmd_ready, 1'b0)
		while (rsp_valid !== 1'b1 && k < 800) begin
			@(negedge clk);
			k++;
		end
		rdata = rsp_rdata;
		`CHK(n_mdc, 66)
		`CHK(cmd_ready, 1'b1)
		repeat (10) @(negedge clk);
	endtask

	task t_write_read;
		n_wr = 0;
		run(1, 5'h1F, 5'h03, 16'hA5C3);
		`CHK(n_wr, 1)
		`CHK({wr_port, wr_reg, wr_data}, {1'b1, 5'h03, 16'hA5C3})
		run(0, 5'h1F, 5'h03, 16'h0000);
		`CHK(rdata, 16'hA5C3)
		$display("write_read done");
	endtask

	task t_update_foreign;
		@(negedge clk);
		{upd_valid, upd_port, upd_reg, upd_data} = {1'b1, 1'b0, 5'h1F, 16'h8001};
		@(negedge clk);
		upd_valid = 0;
		// Update needs the link clock, so a foreign read runs it meanwhile
		run(0, 5'h07, 5'h1F, 16'h0000);
		`CHK(rdata, 16'hFFFF)
		`CHK(upd_ready, 1'b1)
		run(0, 5'h1E, 5'h1F, 16'h0000);
		`CHK(rdata, 16'h8001)
		n_wr = 0;
		run(1, 5'h07, 5'h03, 16'h0F0F);
		`CHK(n_wr, 0)
		run(0, 5'h1F, 5'h03, 16'h0000);
		`CHK(rdata, 16'hA5C3)
		$display("update_foreign done");
	endtask

	task bit1(input logic v, oe);
		link_b.ctl_o = v;
		link_b.ctl_oe = oe;
		#6 link_b.mdc = 1;
		#6 link_b.mdc = 0;
	endtask

	task bb(input int n, input logic [13:0] h, input int exp);
		n_wr_b = 0;
		repeat (n) bit1(1, 1);
		for (int i = 13; i >= 0; i--) bit1(h[i], 1);
		bit1(1, 1);
		bit1(0, 1);
		for (int i = 15; i >= 0; i--) bit1(i[2], 1);
		// Closing pulse, then one idle bit, line released
		bit1(1, 0);
		bit1(1, 0);
		repeat (10) @(negedge clk);
		`CHK(n_wr_b, exp)
	endtask

	task t_frame_faults;
		bb(31, 14'b01_01_00000_00010, 0);
		bb(32, 14'b01_01_00000_00010, 1);
		bb(32, 14'b00_01_00000_00010, 0);
		bb(32, 14'b01_11_00000_00010, 0);
		// Data pattern has bit 6 set, so this write turns preamble suppression on
		bb(32, 14'b01_01_00000_00001, 1);
		bb(3, 14'b01_01_00000_00010, 1);
		$display("frame_faults done");
	endtask

	initial begin
		link_b.mdc = 0;
		link_b.ctl_o = 1;
		link_b.ctl_oe = 0;
		repeat (10) @(posedge clk);
		@(negedge clk);
		sys_rst = 0;
		t_frame_faults();
		t_write_read();
		t_update_foreign();
		stop_test();
	end
endmodule
